// ---- csi_channel_status.sv ----
`timescale 1ns/1ps
// What this block does
// - maintenance register resets to 81h; enable loads 81h, or 01h with search halt
// - bit 7 stays high while the framer hunts for framing
// - signal loss bit follows the loss indicator one cycle later
// - idle bit follows the idle detector, always low in e3 modes
// - yellow bit is high while remote alarm is detected
// - ais bit is high while ais is detected
// - out-of-frame bit follows oof, and oof forces a frame search
// - summary register has one bit per lower status register
// - summary bit is or of unmasked flags, not cleared by reading
// - summary bits may stack; enable affects them only via sources
// - counter flags are active high and set even when masked
// - reading the counter status register clears it
// - counter flags set on rollover or saturation, per select bit
// - x-bit mismatch flag stays low in e3 modes
// - far block error flag low in g751 and m13 modes
// - path parity flag only in c-bit parity mode
// - p-bit mismatch flag stays low in e3 modes
// - parity flag stays low in g751 mode
// - event flags set on event, clear on read or on enable set
// - alarm start register latches sef, loss, idle, yellow, ais starts
// - start bit 0 sets on entering out-of-frame, clears on read
// - alarm end register latches ends of loss, idle, yellow, ais and oof
module csi_channel_status (
  input  wire logic       core_clk,          // 20 MHz clock
  input  wire logic       arst_n,            // async reset, active low
  input  wire logic [7:0] awaddr,            // write address
  input  wire logic       awvalid,           // write address valid
  output logic            awready,           // write address ready
  input  wire logic [31:0] wdata,            // write data
  input  wire logic [3:0] wstrb,             // write strobes
  input  wire logic       wvalid,            // write data valid
  output logic            wready,            // write data ready
  output logic      [1:0] bresp,             // write response
  output logic            bvalid,            // write response valid
  input  wire logic       bready,            // write response ready
  input  wire logic [7:0] araddr,            // read address
  input  wire logic       arvalid,           // read address valid
  output logic            arready,           // read address ready
  output logic     [31:0] rdata,             // read data
  output logic      [1:0] rresp,             // read response
  output logic            rvalid,            // read data valid
  input  wire logic       rready,            // read data ready
  input  wire logic       frameSearchActive, // framer hunting
  input  wire logic       signalLossAlarm,   // loss before decoder
  input  wire logic       idlePatternSeen,   // idle found
  input  wire logic       yellowAlarmSeen,   // rai/rdi detected
  input  wire logic       alarmIndicationSeen, // ais detected
  input  wire logic       outOfFrameAlarm,   // oof detected
  input  wire logic       severeFrameError,  // sef detected
  input  wire logic [7:0] cntRollover,       // counter rollover pulses
  input  wire logic [7:0] cntSaturate,       // counter saturate pulses
  input  wire logic       txLinkFeacSource,  // tx link/feac unmasked flag
  input  wire logic       rxLinkSource,      // rx link unmasked flag
  input  wire logic       rxFeacSource,      // rx feac unmasked flag
  output logic            chanIrq            // channel request, high
);
  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic       awreadyR, wreadyR, bvalidR, arreadyR, rvalidR;
  logic [1:0] brespR, rrespR;
  logic [31:0] rdataR;
  logic       awGot_r, wGot_r;
  logic [7:0] awAddr_r;
  logic [7:0] wByte_r;
  logic       wLane_r;
  logic       doWrite, doRead;
  logic [7:0] ctrl_r, cntMask_r, cntSat_r, startEn_r, endEn_r;
  logic [7:0] maint_r, maintNxt, summary_r, summaryNxt;
  logic       irq_r;
  logic       enPrev_r, enRise;
  logic [1:0] mode;
  logic [5:0] prevLive_r, liveVec, riseVec, fallVec;
  logic [7:0] cntSet, startSet, endSet;
  logic [7:0] cntFlags, startFlags, endFlags;
  logic [7:0] startEnClr, endEnClr;
  logic       rdCnt, rdStart, rdEnd;

  // true for every mapped offset
  function automatic logic mapped(input logic [7:0] a);
    return a[1:0] == 2'h0 && a <= csi_pkg::ADDR_END_EN;
  endfunction

  // ---------------------------------------------------------------
  // axi4-lite write path
  // ---------------------------------------------------------------
  assign doWrite = awGot_r && wGot_r && !bvalidR;

  // address and data are caught in either order
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      awGot_r  <= 1'b0;
      wGot_r   <= 1'b0;
      awreadyR <= 1'b1;
      wreadyR  <= 1'b1;
      awAddr_r <= 8'h00;
      wByte_r  <= 8'h00;
      wLane_r  <= 1'b0;
    end else begin
      if (awvalid && awreadyR) begin
        awGot_r  <= 1'b1;
        awreadyR <= 1'b0;
        awAddr_r <= awaddr;
      end
      if (wvalid && wreadyR) begin
        wGot_r  <= 1'b1;
        wreadyR <= 1'b0;
        wByte_r <= wdata[7:0];
        wLane_r <= wstrb[0];
      end
      if (bvalidR && bready) begin
        awGot_r  <= 1'b0;
        wGot_r   <= 1'b0;
        awreadyR <= 1'b1;
        wreadyR  <= 1'b1;
      end
    end
  end

  // write response one cycle after both halves are held
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      bvalidR <= 1'b0;
      brespR  <= csi_pkg::RESP_OKAY;
    end else if (doWrite) begin
      bvalidR <= 1'b1;
      brespR  <= mapped(awAddr_r) ? csi_pkg::RESP_OKAY : csi_pkg::RESP_SLVERR;
    end else if (bvalidR && bready) begin
      bvalidR <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // control registers written by software
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r    <= 8'h00;
      cntMask_r <= 8'h00;
      cntSat_r  <= 8'h00;
      startEn_r <= 8'h00;
      endEn_r   <= 8'h00;
    end else if (doWrite && wLane_r) begin
      unique case (awAddr_r)
        csi_pkg::ADDR_CTRL:     ctrl_r    <= wByte_r & 8'h33;
        csi_pkg::ADDR_CNT_MASK: cntMask_r <= wByte_r;
        csi_pkg::ADDR_CNT_SAT:  cntSat_r  <= wByte_r;
        csi_pkg::ADDR_START_EN: startEn_r <= wByte_r & 8'h3f;
        csi_pkg::ADDR_END_EN:   endEn_r   <= wByte_r & 8'h1f;
        default: ;
      endcase
    end
  end

  assign mode = ctrl_r[csi_pkg::CTRL_MODE +: 2];

  // enable bits that go from clear to set wipe stale events
  always_comb begin
    startEnClr = csi_pkg::ZERO8;
    endEnClr   = csi_pkg::ZERO8;
    if (doWrite && wLane_r && awAddr_r == csi_pkg::ADDR_START_EN) begin
      startEnClr = wByte_r & ~startEn_r & 8'h3f;
    end
    if (doWrite && wLane_r && awAddr_r == csi_pkg::ADDR_END_EN) begin
      endEnClr = wByte_r & ~endEn_r & 8'h1f;
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite read path
  // ---------------------------------------------------------------
  assign doRead  = arvalid && arreadyR;
  assign rdCnt   = doRead && araddr == csi_pkg::ADDR_CNT_STAT;
  assign rdStart = doRead && araddr == csi_pkg::ADDR_START;
  assign rdEnd   = doRead && araddr == csi_pkg::ADDR_END;

  // one read at a time; data captured on address acceptance
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      arreadyR <= 1'b1;
      rvalidR  <= 1'b0;
      rdataR   <= 32'h0000_0000;
      rrespR   <= csi_pkg::RESP_OKAY;
    end else if (doRead) begin
      arreadyR <= 1'b0;
      rvalidR  <= 1'b1;
      rrespR   <= mapped(araddr) ? csi_pkg::RESP_OKAY : csi_pkg::RESP_SLVERR;
      unique case (araddr)
        csi_pkg::ADDR_MAINT:    rdataR <= {24'h0, maint_r};
        csi_pkg::ADDR_SUMMARY:  rdataR <= {24'h0, summary_r};
        csi_pkg::ADDR_CNT_STAT: rdataR <= {24'h0, cntFlags};
        csi_pkg::ADDR_START:    rdataR <= {24'h0, startFlags};
        csi_pkg::ADDR_END:      rdataR <= {24'h0, endFlags};
        csi_pkg::ADDR_CTRL:     rdataR <= {24'h0, ctrl_r};
        csi_pkg::ADDR_CNT_MASK: rdataR <= {24'h0, cntMask_r};
        csi_pkg::ADDR_CNT_SAT:  rdataR <= {24'h0, cntSat_r};
        csi_pkg::ADDR_START_EN: rdataR <= {24'h0, startEn_r};
        csi_pkg::ADDR_END_EN:   rdataR <= {24'h0, endEn_r};
        default:                rdataR <= 32'h0000_0000;
      endcase
    end else if (rvalidR && rready) begin
      rvalidR  <= 1'b0;
      arreadyR <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // live maintenance indicators
  // ---------------------------------------------------------------
  assign enRise = ctrl_r[csi_pkg::CTRL_EN] && !enPrev_r;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      enPrev_r <= 1'b0;
    end else begin
      enPrev_r <= ctrl_r[csi_pkg::CTRL_EN];
    end
  end

  // next maintenance value from the receive indicators
  always_comb begin
    maintNxt = csi_pkg::ZERO8;
    maintNxt[csi_pkg::MS_SEARCH] = frameSearchActive || outOfFrameAlarm;
    maintNxt[csi_pkg::MS_LOS]  = signalLossAlarm;
    maintNxt[csi_pkg::MS_IDLE] = idlePatternSeen && !csi_pkg::isE3(mode);
    maintNxt[csi_pkg::MS_YEL]  = yellowAlarmSeen;
    maintNxt[csi_pkg::MS_AIS]  = alarmIndicationSeen;
    maintNxt[csi_pkg::MS_OOF]  = outOfFrameAlarm;
  end

  // enable loads the start-up value, otherwise track live state
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      maint_r <= csi_pkg::MAINT_RST;
    end else if (enRise) begin
      maint_r <= ctrl_r[csi_pkg::CTRL_HALT] ? csi_pkg::MAINT_EN_HALT
                                            : csi_pkg::MAINT_RST;
    end else begin
      maint_r <= maintNxt;
    end
  end

  // ---------------------------------------------------------------
  // alarm start and end edges
  // ---------------------------------------------------------------
  assign liveVec = {severeFrameError && !csi_pkg::isE3(mode), signalLossAlarm,
                    idlePatternSeen && !csi_pkg::isE3(mode), yellowAlarmSeen,
                    alarmIndicationSeen, outOfFrameAlarm};
  assign riseVec = liveVec & ~prevLive_r;
  assign fallVec = ~liveVec & prevLive_r;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      prevLive_r <= 6'h00;
    end else begin
      prevLive_r <= liveVec;
    end
  end

  assign startSet = {2'b00, riseVec};
  assign endSet   = {3'b000, fallVec[4:0]};

  // ---------------------------------------------------------------
  // counter flags, gated by framing mode
  // ---------------------------------------------------------------
  assign cntSet = ((cntSaturate & cntSat_r) | (cntRollover & ~cntSat_r))
                  & csi_pkg::cntAllow(mode);

  csi_event_bank uCnt (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .setVec   (cntSet),
    .rdClr    (rdCnt),
    .clrVec   ({8{enRise}}),
    .flags    (cntFlags)
  );

  csi_event_bank uStart (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .setVec   (startSet),
    .rdClr    (rdStart),
    .clrVec   (startEnClr | {8{enRise}}),
    .flags    (startFlags)
  );

  csi_event_bank uEnd (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .setVec   (endSet),
    .rdClr    (rdEnd),
    .clrVec   (endEnClr | {8{enRise}}),
    .flags    (endFlags)
  );

  // ---------------------------------------------------------------
  // interrupt source summary and channel request
  // ---------------------------------------------------------------
  always_comb begin
    summaryNxt = csi_pkg::ZERO8;
    summaryNxt[csi_pkg::SS_TXDL]   = txLinkFeacSource;
    summaryNxt[csi_pkg::SS_RXDL]   = rxLinkSource;
    summaryNxt[csi_pkg::SS_RXFEAC] = rxFeacSource;
    summaryNxt[csi_pkg::SS_END]    = |(endFlags & endEn_r);
    summaryNxt[csi_pkg::SS_START]  = |(startFlags & startEn_r);
    summaryNxt[csi_pkg::SS_CNT]    = |(cntFlags & cntMask_r);
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      summary_r <= 8'h00;
      irq_r     <= 1'b0;
    end else begin
      summary_r <= summaryNxt;
      irq_r     <= |summaryNxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign awready = awreadyR;
  assign wready  = wreadyR;
  assign bvalid  = bvalidR;
  assign bresp   = brespR;
  assign arready = arreadyR;
  assign rvalid  = rvalidR;
  assign rdata   = rdataR;
  assign rresp   = rrespR;
  assign chanIrq = irq_r;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence s_enLoad;
    enRise ##1 1'b1;
  endsequence

  property p_enLoad;
    @(posedge core_clk) disable iff (!arst_n)
      s_enLoad |-> maint_r == ($past(ctrl_r[csi_pkg::CTRL_HALT]) ? csi_pkg::MAINT_EN_HALT
                                                                 : csi_pkg::MAINT_RST);
  endproperty
  a_enLoad: assert property (p_enLoad) else $error("bad enable load");

  property p_search;
    @(posedge core_clk) disable iff (!arst_n)
      frameSearchActive && !enRise |=> maint_r[7];
  endproperty
  a_search: assert property (p_search) else $error("search bit low");

  property p_los;
    @(posedge core_clk) disable iff (!arst_n)
      !enRise |=> maint_r[4] == $past(signalLossAlarm);
  endproperty
  a_los: assert property (p_los) else $error("loss bit wrong");

  property p_idleE3;
    @(posedge core_clk) disable iff (!arst_n)
      csi_pkg::isE3(mode) && !enRise |=> !maint_r[3];
  endproperty
  a_idleE3: assert property (p_idleE3) else $error("idle in e3");

  property p_sumStart;
    @(posedge core_clk) disable iff (!arst_n)
      1'b1 |=> summary_r[1] == $past(|(startFlags & startEn_r));
  endproperty
  a_sumStart: assert property (p_sumStart) else $error("summary wrong");

  property p_cntRdClr;
    @(posedge core_clk) disable iff (!arst_n)
      rdCnt && cntSet == 8'h00 |=> cntFlags == 8'h00 && rvalid;
  endproperty
  a_cntRdClr: assert property (p_cntRdClr) else $error("read no clear");

  property p_xdgrE3;
    @(posedge core_clk) disable iff (!arst_n)
      csi_pkg::isE3(mode) |-> !cntSet[csi_pkg::CI_XDGR] && !cntSet[csi_pkg::CI_PTH];
  endproperty
  a_xdgrE3: assert property (p_xdgrE3) else $error("flag in e3");

  property p_startClr;
    @(posedge core_clk) disable iff (!arst_n)
      startEnClr[2] && !startSet[2] |=> !startFlags[2];
  endproperty
  a_startClr: assert property (p_startClr) else $error("stale event");

  sequence s_oofRise;
    $rose(outOfFrameAlarm) && !enRise;
  endsequence

  property p_oofStart;
    @(posedge core_clk) disable iff (!arst_n)
      s_oofRise |=> startFlags[0] ##1 (!startEn_r[0] || summary_r[1]);
  endproperty
  a_oofStart: assert property (p_oofStart) else $error("oof start lost");

  property p_irq;
    @(posedge core_clk) disable iff (!arst_n)
      chanIrq == (|summary_r);
  endproperty
  a_irq: assert property (p_irq) else $error("request mismatch");
endmodule

// ---- csi_pkg.sv ----
package csi_pkg;
  // ---------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_MAINT     = 8'h00;
  localparam logic [7:0] ADDR_SUMMARY   = 8'h04;
  localparam logic [7:0] ADDR_CNT_STAT  = 8'h08;
  localparam logic [7:0] ADDR_START     = 8'h0c;
  localparam logic [7:0] ADDR_END       = 8'h10;
  localparam logic [7:0] ADDR_CTRL      = 8'h14;
  localparam logic [7:0] ADDR_CNT_MASK  = 8'h18;
  localparam logic [7:0] ADDR_CNT_SAT   = 8'h1c;
  localparam logic [7:0] ADDR_START_EN  = 8'h20;
  localparam logic [7:0] ADDR_END_EN    = 8'h24;
  // ---------------------------------------------------------------
  // reset and load values
  // ---------------------------------------------------------------
  localparam logic [7:0] MAINT_RST      = 8'h81;
  localparam logic [7:0] MAINT_EN_HALT  = 8'h01;
  localparam logic [7:0] ZERO8          = 8'h00;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int MS_SEARCH = 7;
  localparam int MS_LOS    = 4;
  localparam int MS_IDLE   = 3;
  localparam int MS_YEL    = 2;
  localparam int MS_AIS    = 1;
  localparam int MS_OOF    = 0;
  localparam int SS_TXDL   = 5;
  localparam int SS_RXDL   = 4;
  localparam int SS_RXFEAC = 3;
  localparam int SS_END    = 2;
  localparam int SS_START  = 1;
  localparam int SS_CNT    = 0;
  localparam int CI_EXZ    = 7;
  localparam int CI_XDGR   = 6;
  localparam int CI_LCV    = 5;
  localparam int CI_FEBE   = 4;
  localparam int CI_PTH    = 3;
  localparam int CI_FERR   = 2;
  localparam int CI_PDGR   = 1;
  localparam int CI_PAR    = 0;
  localparam int AS_SEF    = 5;
  localparam int CTRL_EN   = 0;
  localparam int CTRL_HALT = 1;
  localparam int CTRL_MODE = 4;
  // ---------------------------------------------------------------
  // framing modes and bus answers
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_M13  = 2'h0;
  localparam logic [1:0] MODE_CBIT = 2'h1;
  localparam logic [1:0] MODE_G751 = 2'h2;
  localparam logic [1:0] MODE_G832 = 2'h3;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // e3 modes have the upper mode bit set
  function automatic logic isE3(input logic [1:0] mode);
    return mode[1];
  endfunction

  // counter flags that can exist in a framing mode
  function automatic logic [7:0] cntAllow(input logic [1:0] mode);
    logic [7:0] m;
    m = 8'hff;
    if (isE3(mode)) begin
      m[CI_XDGR] = 1'b0;
      m[CI_PDGR] = 1'b0;
    end
    if (mode != MODE_CBIT) begin
      m[CI_PTH] = 1'b0;
    end
    if (mode == MODE_M13 || mode == MODE_G751) begin
      m[CI_FEBE] = 1'b0;
    end
    if (mode == MODE_G751) begin
      m[CI_PAR] = 1'b0;
    end
    return m;
  endfunction
endpackage

// ---- csi_event_bank.sv ----
`timescale 1ns/1ps
// sticky flags: hardware sets, read or enable clears, set wins
module csi_event_bank (
  input  wire logic       core_clk, // system clock
  input  wire logic       arst_n,   // async reset, active low
  input  wire logic [7:0] setVec,   // per-flag set pulses
  input  wire logic       rdClr,    // register read clears all
  input  wire logic [7:0] clrVec,   // per-flag clears
  output logic      [7:0] flags     // sticky flag state
);
  logic [7:0] flags_r;
  logic [7:0] clrAll;

  // combine the clear sources
  assign clrAll = clrVec | {8{rdClr}};

  // a set in the clearing cycle is kept
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      flags_r <= 8'h00;
    end else begin
      flags_r <= (flags_r & ~clrAll) | setVec;
    end
  end

  assign flags = flags_r;
endmodule

// ---- csi_testbench.sv ----
`timescale 1ns/1ps
`define CHK(got, exp) begin nChecks++; if ((got) !== (exp)) begin mismatches++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end end
module testbench;
  // ---------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------
  logic        core_clk = 1'b0;
  logic        arst_n   = 1'b0;
  logic [7:0]  awaddr   = 8'h00;
  logic [7:0]  araddr   = 8'h00;
  logic        awvalid  = 1'b0;
  logic        wvalid   = 1'b0;
  logic        bready   = 1'b0;
  logic        arvalid  = 1'b0;
  logic        rready   = 1'b0;
  logic [31:0] wdata    = 32'h0000_0000;
  logic [3:0]  wstrb    = 4'hf;
  logic        awready, wready, bvalid, arready, rvalid, chanIrq;
  logic [1:0]  bresp, rresp, rsp;
  logic [31:0] rdata, rdVal;
  logic        search = 1'b1, loss = 1'b0, idle = 1'b0, yel = 1'b0;
  logic        ais = 1'b0, oof = 1'b1, sef = 1'b0;
  logic        txSrc = 1'b0, rxSrc = 1'b0, feacSrc = 1'b0;
  logic [7:0]  roll = 8'h00, sat = 8'h00;
  logic [7:0]  allowTbl [4] = '{8'he7, 8'hff, 8'ha4, 8'hb5}; // flags per mode m13,cbit,g751,g832
  int          mismatches = 0;
  int          nChecks = 0;

  // clock at 20 MHz
  always #25 core_clk = ~core_clk;

  csi_channel_status uut (
    .core_clk(core_clk), .arst_n(arst_n), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .frameSearchActive(search), .signalLossAlarm(loss), .idlePatternSeen(idle),
    .yellowAlarmSeen(yel), .alarmIndicationSeen(ais), .outOfFrameAlarm(oof),
    .severeFrameError(sef), .cntRollover(roll), .cntSaturate(sat),
    .txLinkFeacSource(txSrc), .rxLinkSource(rxSrc), .rxFeacSource(feacSrc),
    .chanIrq(chanIrq));

  // ---------------------------------------------------------------
  // bus tasks
  // ---------------------------------------------------------------
  // write: address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aTk, wTk;
    @(posedge core_clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(negedge core_clk);
      aTk = awvalid && awready;
      wTk = wvalid && wready;
      @(posedge core_clk);
      if (aTk) awvalid <= 1'b0;
      if (wTk) wvalid <= 1'b0;
    end while (!(aTk && wTk) && (awvalid || wvalid));
    do @(negedge core_clk); while (!bvalid);
    rsp = bresp;
    @(posedge core_clk);
    bready <= 1'b0;
  endtask

  // read: rready held until the answer edge
  task automatic rd(input logic [7:0] a);
    logic aTk;
    @(posedge core_clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(negedge core_clk);
      aTk = arvalid && arready;
      @(posedge core_clk);
      if (aTk) arvalid <= 1'b0;
    end while (!aTk);
    do @(negedge core_clk); while (!rvalid);
    rdVal = rdata;
    rsp = rresp;
    @(posedge core_clk);
    rready <= 1'b0;
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    `CHK(rdVal, {24'h0, e})
  endtask

  task automatic settle();
    repeat (4) @(posedge core_clk);
  endtask

  // one-cycle counter pulses
  task automatic pulse(input logic [7:0] r, input logic [7:0] s);
    @(posedge core_clk);
    roll <= r; sat <= s;
    @(posedge core_clk);
    roll <= 8'h00; sat <= 8'h00;
    settle();
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", nChecks, mismatches);
    if (mismatches == 0 && nChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    rdChk(csi_pkg::ADDR_MAINT, 8'h81);
    rdChk(csi_pkg::ADDR_SUMMARY, 8'h00);
    rd(8'h28);
    `CHK(rsp, csi_pkg::RESP_SLVERR)
    `CHK(rdVal, 32'h0)
    wr(csi_pkg::ADDR_MAINT, 32'hff);
    `CHK(rsp, csi_pkg::RESP_OKAY)
    rdChk(csi_pkg::ADDR_MAINT, 8'h81);
    // enable with search halt loads 01h for one cycle, watched by a_enLoad
    wr(csi_pkg::ADDR_CTRL, 32'h03);
    wr(csi_pkg::ADDR_CTRL, 32'h00);
    rdChk(csi_pkg::ADDR_MAINT, 8'h81);
    // live alarm levels in c-bit, then an e3 mode
    search <= 1'b0; oof <= 1'b0; loss <= 1'b1; idle <= 1'b1; yel <= 1'b1; ais <= 1'b1;
    wr(csi_pkg::ADDR_CTRL, 32'h11);
    settle();
    rdChk(csi_pkg::ADDR_MAINT, 8'h1e);
    wr(csi_pkg::ADDR_CTRL, 32'h21);
    settle();
    rdChk(csi_pkg::ADDR_MAINT, 8'h16);
    wr(csi_pkg::ADDR_CTRL, 32'h11);
    search <= 1'b1; loss <= 1'b0; idle <= 1'b0; yel <= 1'b0; ais <= 1'b0;
    settle();
    rdChk(csi_pkg::ADDR_MAINT, 8'h80);
    search <= 1'b0; oof <= 1'b1;
    settle();
    rdChk(csi_pkg::ADDR_MAINT, 8'h81);
    oof <= 1'b0;
    // counter flags in every framing mode
    wr(csi_pkg::ADDR_CNT_MASK, 32'hff);
    for (int i = 0; i < 4; i++) begin
      wr(csi_pkg::ADDR_CTRL, (i << 4) | 1);
      pulse(8'hff, 8'h00);
      @(negedge core_clk);
      `CHK(chanIrq, 1'b1)
      rdChk(csi_pkg::ADDR_SUMMARY, 8'h01);
      rdChk(csi_pkg::ADDR_CNT_STAT, allowTbl[i]);
      rdChk(csi_pkg::ADDR_CNT_STAT, 8'h00);
      rdChk(csi_pkg::ADDR_SUMMARY, 8'h00);
    end
    wr(csi_pkg::ADDR_CTRL, 32'h11);
    wr(csi_pkg::ADDR_CNT_SAT, 32'h01);
    pulse(8'h01, 8'h00);
    rdChk(csi_pkg::ADDR_CNT_STAT, 8'h00);
    pulse(8'h00, 8'h01);
    rdChk(csi_pkg::ADDR_CNT_STAT, 8'h01);
    wr(csi_pkg::ADDR_CNT_MASK, 32'h00);
    pulse(8'hfe, 8'h00);
    rdChk(csi_pkg::ADDR_SUMMARY, 8'h00);
    @(negedge core_clk);
    `CHK(chanIrq, 1'b0)
    rdChk(csi_pkg::ADDR_CNT_STAT, 8'hfe);
    // alarm start and end events
    wr(csi_pkg::ADDR_START_EN, 32'h3f);
    wr(csi_pkg::ADDR_END_EN, 32'h1f);
    rdChk(csi_pkg::ADDR_START, 8'h00);
    rdChk(csi_pkg::ADDR_END, 8'h00);
    oof <= 1'b1; loss <= 1'b1; sef <= 1'b1;
    settle();
    rdChk(csi_pkg::ADDR_SUMMARY, 8'h02);
    rdChk(csi_pkg::ADDR_START, 8'h31);
    rdChk(csi_pkg::ADDR_START, 8'h00);
    oof <= 1'b0; loss <= 1'b0; sef <= 1'b0;
    settle();
    rdChk(csi_pkg::ADDR_END, 8'h11);
    rdChk(csi_pkg::ADDR_END, 8'h00);
    yel <= 1'b1;
    settle();
    wr(csi_pkg::ADDR_START_EN, 32'h3b);
    wr(csi_pkg::ADDR_START_EN, 32'h3f);
    rdChk(csi_pkg::ADDR_START, 8'h00);
    // several summary sources at once
    txSrc <= 1'b1; rxSrc <= 1'b1; feacSrc <= 1'b1; yel <= 1'b0;
    settle();
    rdChk(csi_pkg::ADDR_SUMMARY, 8'h3c);
    rdChk(csi_pkg::ADDR_END, 8'h04);
    settle();
    rdChk(csi_pkg::ADDR_SUMMARY, 8'h38);
    txSrc <= 1'b0; rxSrc <= 1'b0; feacSrc <= 1'b0;
    settle();
    @(negedge core_clk);
    `CHK(chanIrq, 1'b0)
    summarize();
  end

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    summarize();
  end
endmodule
